// file: lpddr_pin_consts.vh
// Purpose: Constants for the DRAM pin-level command and data interface
// Assumes: 100 MHz mclk_i oversamples the differential clock pair
// Notes:   Summary list follows
//
// Summary of operation
// R1: Sample controls at true-rise clock crossing
// R2: Read data timed to both clock crossings
// R3: Clock enable low stops clocks, buffers, drivers
// R4: Idle banks: precharge power-down; else active power-down
// R5: Clock enable synchronous except self refresh exit
// R6: Decode commands only with chip select low
// R7: Command from row, column, write strobes
// R8: Bank select picks bank for commands
// R9: Bank select picks mode register target
// R10: Address carries row, or column plus bit ten
// R11: Precharge scope bit low: one bank, high: all
// R12: Large page: row bits 0-11, column 0-8
// R13: Small page: row bits 0-12, column 0-7
// R14: High write mask discards the byte
// R15: Masks sampled on both strobe edges
// R16: Mask n governs byte lane n
// R17: Device drives strobes on reads only
// R18: Read strobe edges aligned with data
// R19: Strobe n serves byte lane n
// R20: Bank select 2: extended, 1: status register
// R21: Data and strobes released when not reading
// R22: Controller closes banks before self refresh
`ifndef LPDDR_PIN_CONSTS_VH
`define LPDDR_PIN_CONSTS_VH
`define CMD_NOP        3'h7
`define CMD_ACTIVATE   3'h3
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define CMD_TERMINATE  3'h6
`define CMD_PRECHARGE  3'h2
`define CMD_REFRESH    3'h1
`define CMD_MODE       3'h0
`define SEL_MODE_REG   2'h0
`define SEL_STATUS_REG 2'h1
`define SEL_EXT_MODE   2'h2
`define SCOPE_BIT      10
`define BURST_DEFAULT  4'h4
`define CL_DEFAULT     2'h3
`define STATUS_WORD    32'h0000_0000
`endif

// file: lpddr_pin_if.v
// Purpose: Device-side command decode, bank state, power states, read burst
// Assumes: All pins asynchronous to mclk_i; link clock about 160 ns period
// Notes:   Array is a small flip-flop store indexed by bank and column
`timescale 1ns/1ps
`include "lpddr_pin_consts.vh"
module lpddr_pin_if #(
    parameter ROW_W   = 13,
    parameter COL_W   = 9,
    parameter BIG_PAGE = 1,
    parameter MEM_AW  = 4
) (
    input  wire        mclk_i,            // System clock
    input  wire        rstn_i,            // Sync reset, active low
    input  wire        diff_clock_pair_i, // True clock of pair
    input  wire        cke_i,             // Clock enable
    input  wire        cs_n_i,            // Chip select, low active
    input  wire        ras_n_i,           // Row strobe
    input  wire        cas_n_i,           // Column strobe
    input  wire        we_n_i,            // Write strobe
    input  wire [1:0]  bank_select_i,     // Bank select
    input  wire [12:0] addr_i,            // Multiplexed address
    input  wire [31:0] data_lines_i,      // Data in
    input  wire [3:0]  byte_write_mask_i, // Write masks
    input  wire [3:0]  byte_data_strobe_i,// Strobes in
    output reg  [31:0] data_lines_o,      // Data out
    output reg         data_lines_oe_o,   // Data drive enable
    output reg  [3:0]  byte_data_strobe_o,// Strobes out
    output reg  [3:0]  byte_data_strobe_oe_o, // Strobe drive enable
    output reg  [3:0]  bank_open_o,       // Row open per bank
    output reg  [1:0]  power_state_o,     // 0 run,1 pre pd,2 act pd,3 self ref
    output reg         read_stall_o       // Read word held by buffer
);
// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Two flip-flops per pin before any logic reads it
reg        ck_s1_q;
reg        ck_s2_q;
reg        cke_s1_q;
reg        cke_s2_q;
reg        cs_s1_q;
reg        cs_s2_q;
reg [2:0]  cmd_s1_q;
reg [2:0]  cmd_s2_q;
reg [1:0]  ba_s1_q;
reg [1:0]  ba_s2_q;
reg [12:0] a_s1_q;
reg [12:0] a_s2_q;
reg [31:0] dq_s1_q;
reg [31:0] dq_s2_q;
reg [3:0]  dm_s1_q;
reg [3:0]  dm_s2_q;
reg [3:0]  dqs_s1_q;
reg [3:0]  dqs_s2_q;
reg [3:0]  dqs_prev_q;
reg        clk_prev_q;
wire        ck    = ck_s2_q;
wire        cke   = cke_s2_q;
wire        cs_n  = cs_s2_q;
wire [2:0]  cmd   = cmd_s2_q;
wire [1:0]  ba    = ba_s2_q;
wire [12:0] a     = a_s2_q;
wire [31:0] dq_in = dq_s2_q;
wire [3:0]  dm    = dm_s2_q;

always @(posedge mclk_i) begin
    ck_s1_q  <= diff_clock_pair_i;
    cke_s1_q <= cke_i;
    cs_s1_q  <= cs_n_i;
    cmd_s1_q <= {ras_n_i, cas_n_i, we_n_i};
    ba_s1_q  <= bank_select_i;
    a_s1_q   <= addr_i;
    dq_s1_q  <= data_lines_i;
    dm_s1_q  <= byte_write_mask_i;
    dqs_s1_q <= byte_data_strobe_i;
    ck_s2_q  <= ck_s1_q;
    cke_s2_q <= cke_s1_q;
    cs_s2_q  <= cs_s1_q;
    cmd_s2_q <= cmd_s1_q;
    ba_s2_q  <= ba_s1_q;
    a_s2_q   <= a_s1_q;
    dq_s2_q  <= dq_s1_q;
    dm_s2_q  <= dm_s1_q;
    dqs_s2_q <= dqs_s1_q;
end
// ----------------------------------------------------------------
// Clock crossing detection
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        clk_prev_q <= 1'b0;
        dqs_prev_q <= 4'h0;
    end else begin
        clk_prev_q <= ck;
        dqs_prev_q <= dqs_s2_q;
    end
end
wire ck_rise = ck & ~clk_prev_q;      // R1
wire ck_fall = ~ck & clk_prev_q;
wire ck_edge = ck_rise | ck_fall;     // R2
// ----------------------------------------------------------------
// Power state
// ----------------------------------------------------------------
localparam PS_RUN = 2'h0;
localparam PS_PPD = 2'h1;
localparam PS_APD = 2'h2;
localparam PS_SR  = 2'h3;
reg  [1:0] ps_q;
reg        cke_prev_q;
wire       all_idle = ~|bank_open_o;
wire [2:0] cmd_now = cs_n ? `CMD_NOP : cmd;            // R6 R7
wire       running = (ps_q == PS_RUN);                 // R3
wire       dec_en  = ck_rise & running & cke & cke_prev_q & ~cs_n; // R6
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        ps_q       <= PS_RUN;
        cke_prev_q <= 1'b1;
    end else begin
        if (ps_q == PS_SR && cke) begin
            ps_q <= PS_RUN;                            // R5
        end else if (ck_rise) begin
            cke_prev_q <= cke;
            case (ps_q)
                PS_RUN: begin
                    if (!cke && cke_prev_q) begin
                        if (!all_idle)
                            ps_q <= PS_APD;            // R4
                        else if (!cs_n && cmd == `CMD_REFRESH)
                            ps_q <= PS_SR;             // R4 R22
                        else
                            ps_q <= PS_PPD;            // R4
                    end
                end
                PS_PPD, PS_APD: begin
                    if (cke)
                        ps_q <= PS_RUN;                // R5
                end
                default: ps_q <= ps_q;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Power state output
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (!rstn_i)
        power_state_o <= PS_RUN;
    else
        power_state_o <= ps_q;
end

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
wire       is_act  = dec_en && (cmd_now == `CMD_ACTIVATE);           // R7
wire       is_pre  = dec_en && (cmd_now == `CMD_PRECHARGE);
wire       is_rd   = dec_en && (cmd_now == `CMD_READ);
wire       is_wr   = dec_en && (cmd_now == `CMD_WRITE);
wire       is_rdwr = is_rd | is_wr;
wire       is_term = dec_en && (cmd_now == `CMD_TERMINATE);
wire       is_mode = dec_en && (cmd_now == `CMD_MODE);
wire       is_srr  = is_mode && (ba == `SEL_STATUS_REG);           // R9 R20
// ----------------------------------------------------------------
// Mode registers and banks
// ----------------------------------------------------------------
reg [12:0] mode_q;
reg [12:0] ext_mode_q;
reg [ROW_W-1:0] row_q [0:3];
wire [3:0] burst_len = (mode_q[2:0] == 3'h1) ? 4'h2 :
                       (mode_q[2:0] == 3'h3) ? 4'h8 : `BURST_DEFAULT;
wire [1:0] cas_lat = (mode_q[6:4] == 3'h2) ? 2'h2 : `CL_DEFAULT;
// R12 R13
wire [ROW_W-1:0] row_addr = BIG_PAGE ? {1'b0, a[11:0]} : a[ROW_W-1:0];
wire [COL_W-1:0] col_addr = BIG_PAGE ? a[8:0] : {1'b0, a[7:0]};
// ----------------------------------------------------------------
// Bank state
// ----------------------------------------------------------------
wire [3:0] bank_hit = 4'h1 << ba;                                  // R8
wire       auto_pc  = a[`SCOPE_BIT];                               // R10 R11
wire [3:0] open_d;
genvar gb;
generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_bank
        // Activate opens; precharge or auto precharge closes
        wire close_pre = is_pre & (auto_pc | bank_hit[gb]);       // R11
        wire close_apc = is_rdwr & auto_pc & bank_hit[gb];        // R10
        assign open_d[gb] = (is_act & bank_hit[gb]) |              // R8 R10
                            (bank_open_o[gb] & ~close_pre & ~close_apc);
    end
endgenerate

always @(posedge mclk_i) begin
    if (!rstn_i)
        bank_open_o <= 4'h0;
    else
        bank_open_o <= open_d;
end

always @(posedge mclk_i) begin
    if (is_act)
        row_q[ba] <= row_addr;                                     // R8 R10
end

// ----------------------------------------------------------------
// Mode register load
// ----------------------------------------------------------------
reg sr_read_q;
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        mode_q     <= 13'h0032 | {9'h000, `BURST_DEFAULT == 4'h4 ? 4'h2 : 4'h1};
        ext_mode_q <= 13'h0020;
    end else if (is_mode) begin
        case (ba)                                                 // R9 R20
            `SEL_MODE_REG: mode_q     <= a;
            `SEL_EXT_MODE: ext_mode_q <= a;
            default: ;
        endcase
    end
end
// ----------------------------------------------------------------
// Storage and write capture
// ----------------------------------------------------------------
reg [31:0] mem_q [0:(1<<MEM_AW)-1];
reg [MEM_AW-1:0] wr_ptr_q;
reg [3:0]  wr_left_q;
wire [3:0] dqs_edge = dqs_s2_q ^ dqs_prev_q;
wire [MEM_AW-1:0] base_idx = {ba, col_addr[MEM_AW-3:0]};
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        wr_ptr_q  <= {MEM_AW{1'b0}};
        wr_left_q <= 4'h0;
    end else if (is_wr) begin
        wr_ptr_q  <= base_idx;
        wr_left_q <= burst_len;
    end else if (wr_left_q != 4'h0 && dqs_edge[0]) begin         // R15 R17
        wr_ptr_q  <= wr_ptr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
        wr_left_q <= wr_left_q - 4'h1;
    end
end
// ----------------------------------------------------------------
// Write merge
// ----------------------------------------------------------------
wire [31:0] wr_word;
wire        wr_any = (wr_left_q != 4'h0) && (dqs_edge != 4'h0);
genvar gl;
generate
    for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
        // Lane gl uses mask gl and strobe gl; other lanes keep old bytes
        wire lane_keep = (wr_left_q != 4'h0) && dqs_edge[gl] && !dm[gl];   // R14 R16 R19
        assign wr_word[gl*8+7:gl*8] = lane_keep ? dq_in[gl*8+7:gl*8] :
                                                  mem_q[wr_ptr_q][gl*8+7:gl*8];
    end
endgenerate

always @(posedge mclk_i) begin
    if (wr_any)
        mem_q[wr_ptr_q] <= wr_word;
end
// ----------------------------------------------------------------
// Read burst and two-entry output buffer
// ----------------------------------------------------------------
reg [3:0]  rd_left_q;
reg [1:0]  rd_wait_q;
reg [MEM_AW-1:0] rd_ptr_q;
reg [31:0] buf_q [0:1];
reg [1:0]  buf_cnt_q;
reg        buf_rd_q;
reg        buf_wr_q;
wire       src_valid = (rd_left_q != 4'h0) && (rd_wait_q == 2'h0);
wire       src_ready = (buf_cnt_q != 2'h2);
wire       src_push  = src_valid & src_ready & ck_edge;
wire       snk_pop   = (buf_cnt_q != 2'h0) & ck_edge & running;  // R2 R3
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        rd_left_q <= 4'h0;
        rd_wait_q <= 2'h0;
        rd_ptr_q  <= {MEM_AW{1'b0}};
        sr_read_q <= 1'b0;
    end else if (is_rd || is_srr) begin                               // R9 R20
        rd_left_q <= is_rd ? burst_len : 4'h2;
        rd_wait_q <= cas_lat - 2'h1;
        rd_ptr_q  <= base_idx;
        sr_read_q <= is_srr;
    end else if (is_term || is_wr) begin
        rd_left_q <= 4'h0;
    end else if (ck_rise && rd_wait_q != 2'h0) begin
        rd_wait_q <= rd_wait_q - 2'h1;
    end else if (src_push) begin
        rd_left_q <= rd_left_q - 4'h1;
        rd_ptr_q  <= rd_ptr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
    end
end

// ----------------------------------------------------------------
// Output buffer
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        buf_cnt_q <= 2'h0;
        buf_rd_q  <= 1'b0;
        buf_wr_q  <= 1'b0;
    end else begin
        if (src_push) begin
            buf_q[buf_wr_q] <= sr_read_q ? `STATUS_WORD : mem_q[rd_ptr_q];
            buf_wr_q        <= ~buf_wr_q;
        end
        if (snk_pop)
            buf_rd_q <= ~buf_rd_q;
        case ({src_push, snk_pop})
            2'b10:   buf_cnt_q <= buf_cnt_q + 2'h1;
            2'b01:   buf_cnt_q <= buf_cnt_q - 2'h1;
            default: buf_cnt_q <= buf_cnt_q;
        endcase
    end
end
// ----------------------------------------------------------------
// Pin drive
// ----------------------------------------------------------------
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        data_lines_o          <= 32'h0000_0000;
        data_lines_oe_o       <= 1'b0;
        byte_data_strobe_o    <= 4'h0;
        byte_data_strobe_oe_o <= 4'h0;
        read_stall_o          <= 1'b0;
    end else begin
        read_stall_o <= src_valid & ~src_ready;
        if (snk_pop) begin
            data_lines_o       <= buf_q[buf_rd_q];
            data_lines_oe_o    <= 1'b1;                          // R17
            byte_data_strobe_o <= {4{ck}};                       // R18
            byte_data_strobe_oe_o <= 4'hf;
        end else if (buf_cnt_q == 2'h0 && !src_valid && ck_edge) begin
            data_lines_oe_o       <= 1'b0;                       // R21
            byte_data_strobe_oe_o <= 4'h0;                       // R21
            byte_data_strobe_o    <= 4'h0;
        end else if (!running) begin
            data_lines_oe_o       <= 1'b0;                       // R3
            byte_data_strobe_oe_o <= 4'h0;
        end
    end
end
endmodule // lpddr_pin_if

// file: lpddr_pin_if_asserts.sv
// Purpose: Port assertions for the DRAM pin interface
// Assumes: Only top ports visible
// Notes:   Bound from the testbench file
`timescale 1ns/1ps
module lpddr_pin_if_asserts (
    input wire        mclk_i,                // Clock
    input wire        rstn_i,                // Reset, low
    input wire        cke_i,                 // Clock enable
    input wire        cs_n_i,                // Chip select
    input wire [31:0] data_lines_o,          // Read data
    input wire        data_lines_oe_o,       // Data drive
    input wire [3:0]  byte_data_strobe_o,    // Strobes
    input wire [3:0]  byte_data_strobe_oe_o, // Strobe drive
    input wire [3:0]  bank_open_o,           // Open rows
    input wire [1:0]  power_state_o          // Power state
);
    logic [7:0] cs_hi_q; // Cycles with chip select high
    always @(posedge mclk_i) begin
        if (!rstn_i || !cs_n_i) cs_hi_q <= 8'h00;
        else if (cs_hi_q != 8'hff) cs_hi_q <= cs_hi_q + 8'h01;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence cke_held_low;
        $fell(cke_i) ##1 (!cke_i)[*8];
    endsequence
    sequence first_word;
        $rose(data_lines_oe_o);
    endsequence
    AST_OE_STROBES: assert property (data_lines_oe_o |-> byte_data_strobe_oe_o == 4'hf)
        else $error("strobe drive missing while data driven");
    AST_RELEASED: assert property (!data_lines_oe_o |-> byte_data_strobe_oe_o == 4'h0)
        else $error("strobes driven outside a read");
    AST_PD_QUIET: assert property (power_state_o != 2'h0 |-> !data_lines_oe_o)
        else $error("drivers on in power down");
    AST_PD_ENTRY: assert property (cke_held_low |-> ##[0:30] power_state_o != 2'h0)
        else $error("no power down after enable low");
    AST_PD_ACTIVE: assert property ($changed(power_state_o) && power_state_o == 2'h2 |-> bank_open_o != 4'h0)
        else $error("active power down with banks idle");
    AST_PD_IDLE: assert property ($changed(power_state_o) && power_state_o == 2'h1 |-> bank_open_o == 4'h0)
        else $error("precharge power down with a row open");
    AST_SR_EXIT: assert property (power_state_o == 2'h3 && cke_i |-> ##[1:6] power_state_o == 2'h0)
        else $error("self refresh exit late");
    AST_CS_MASK: assert property (cs_hi_q > 8'h05 |-> $stable(bank_open_o))
        else $error("bank state changed with chip select high");
    AST_EDGE_ALIGN: assert property (data_lines_oe_o && $past(data_lines_oe_o) && $stable(byte_data_strobe_o)
        |-> $stable(data_lines_o))
        else $error("read data moved without strobe edge");
    AST_DDR_WORDS: assert property (first_word |-> ##[1:12] $changed(byte_data_strobe_o))
        else $error("no second word in read burst");
endmodule // lpddr_pin_if_asserts

// file: lpddr_ctrl_model.sv
// Purpose: Controller model driving the DRAM pins
// Assumes: Pair clock 160 ns, free phase to mclk_i
// Notes:   Pair clock can stop during self refresh
`timescale 1ns/1ps
module lpddr_ctrl_model (
    output logic        pair_clk_o, // True pair clock
    output logic        cke_o,      // Clock enable
    output logic        cs_n_o,     // Chip select
    output logic        ras_n_o,    // Row strobe
    output logic        cas_n_o,    // Column strobe
    output logic        we_n_o,     // Write strobe
    output logic [1:0]  bank_o,     // Bank select
    output logic [12:0] addr_o,     // Address
    output logic [31:0] wdata_o,    // Write data
    output logic        wdata_oe_o, // Write data drive
    output logic [3:0]  wmask_o,    // Write masks
    output logic [3:0]  wstb_o,     // Write strobes
    output logic [3:0]  wstb_oe_o   // Strobe drive
);
    logic run_q = 1'b1; // Pair clock runs
    initial begin
        {pair_clk_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 6'h1f;
        {bank_o, addr_o, wdata_o, wdata_oe_o, wmask_o, wstb_o, wstb_oe_o} = '0;
        #3;
        forever begin
            #80;
            if (run_q) pair_clk_o = ~pair_clk_o;
        end
    end
    // Command set up half a period before the rising crossing
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                         input logic cs_n, input logic cke);
        @(negedge pair_clk_o);
        {ras_n_o, cas_n_o, we_n_o} = c;
        cs_n_o = cs_n;
        bank_o = b;
        addr_o = a;
        cke_o = cke;
        @(negedge pair_clk_o);
        {ras_n_o, cas_n_o, we_n_o} = 3'h7;
        cs_n_o = 1'b0;
        addr_o = ~a;
    endtask
    task automatic wr_burst(input logic [127:0] w, input logic [15:0] m);
        @(posedge pair_clk_o);
        wdata_oe_o = 1'b1;
        wstb_oe_o = 4'hf;
        for (int i = 0; i < 4; i++) begin
            wdata_o = w[32*i +: 32];
            wmask_o = m[4*i +: 4];
            #40;
            wstb_o = ~wstb_o;
            #40;
        end
        {wdata_oe_o, wstb_oe_o} = 5'h00;
        wdata_o = ~wdata_o;
        wstb_o = ~wstb_o;
    endtask
endmodule // lpddr_ctrl_model

// file: testbench.sv
// Purpose: Self-checking bench for the DRAM pin interface
// Assumes: Controller model drives all pins
// Notes:   Read words captured on each strobe change
`timescale 1ns/1ps
module testbench;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    wire         pclk, cke, cs_n, ras_n, cas_n, we_n, c_oe, d_oe, stall;
    wire  [1:0]  bank, pstate;
    wire  [12:0] addr;
    wire  [31:0] c_data, d_data, bus_data;
    wire  [3:0]  c_mask, c_stb, c_stb_oe, d_stb, d_stb_oe, bus_stb, open;
    logic [31:0] got [8];
    int          ng = 0;
    logic        oe_q = 1'b0;
    logic        stb_q = 1'b0;
    int          n_tests = 0;
    int          n_mismatch = 0;
    always #5 mclk_i = ~mclk_i;
    assign bus_data = d_oe ? d_data : c_data;
    assign bus_stb = (d_stb_oe & d_stb) | (~d_stb_oe & c_stb);
    lpddr_ctrl_model ctl (.pair_clk_o(pclk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .bank_o(bank), .addr_o(addr), .wdata_o(c_data), .wdata_oe_o(c_oe), .wmask_o(c_mask),
        .wstb_o(c_stb), .wstb_oe_o(c_stb_oe));
    lpddr_pin_if i_lpddr_pin_if (.mclk_i(mclk_i), .rstn_i(rstn_i), .diff_clock_pair_i(pclk), .cke_i(cke),
        .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_i(bank), .addr_i(addr),
        .data_lines_i(bus_data), .byte_write_mask_i(c_mask), .byte_data_strobe_i(bus_stb),
        .data_lines_o(d_data), .data_lines_oe_o(d_oe), .byte_data_strobe_o(d_stb),
        .byte_data_strobe_oe_o(d_stb_oe), .bank_open_o(open), .power_state_o(pstate), .read_stall_o(stall));
    always @(negedge mclk_i) begin
        if (d_oe === 1'b1 && (!oe_q || d_stb[0] !== stb_q) && ng < 8) begin
            got[ng] = d_data;
            ng++;
        end
        oe_q = d_oe;
        stb_q = d_stb[0];
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        repeat (8) @(negedge mclk_i);
    endtask
    task automatic wait_ps(input logic [1:0] v);
        for (int k = 0; k < 80 && pstate !== v; k++) @(negedge mclk_i);
        chk(32'(pstate), 32'(v));
    endtask
    task automatic read_words(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
        ng = 0;
        ctl.issue(c, b, a, 1'b0, 1'b1);
        for (int k = 0; k < 100 && d_oe !== 1'b1; k++) @(negedge mclk_i);
        for (int k = 0; k < 100 && d_oe !== 1'b0; k++) @(negedge mclk_i);
    endtask
    function automatic logic [31:0] lanes(input logic [3:0] m);
        return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction
    task automatic t_banks;
        ctl.issue(3'h3, 2'h1, 13'h0123, 1'b1, 1'b1);
        settle();
        chk(32'(open), 32'h0000_0000);
        ctl.issue(3'h3, 2'h1, 13'h0fff, 1'b0, 1'b1);
        ctl.issue(3'h3, 2'h2, 13'h0001, 1'b0, 1'b1);
        settle();
        chk(32'(open), 32'h0000_0006);
        ctl.issue(3'h2, 2'h1, 13'h0000, 1'b0, 1'b1);
        settle();
        chk(32'(open), 32'h0000_0004);
        ctl.issue(3'h3, 2'h3, 13'h0002, 1'b0, 1'b1);
        ctl.issue(3'h2, 2'h0, 13'h0400, 1'b0, 1'b1);
        settle();
        chk(32'(open), 32'h0000_0000);
    endtask
    task automatic t_write_read;
        logic [127:0] wa;
        logic [127:0] wb;
        logic [15:0]  m;
        m = 16'h1040;
        for (int k = 0; k < 4; k++) begin
            wa[32*k +: 32] = 32'h0101_0101 * (k + 1);
            wb[32*k +: 32] = 32'h8040_2010 + k;
        end
        ctl.issue(3'h3, 2'h1, 13'h0010, 1'b0, 1'b1);
        ctl.issue(3'h4, 2'h1, 13'h0000, 1'b0, 1'b1);
        ctl.wr_burst(wa, 16'h0000);
        ctl.issue(3'h4, 2'h1, 13'h0000, 1'b0, 1'b1);
        ctl.wr_burst(wb, m);
        read_words(3'h5, 2'h1, 13'h0000);
        chk(32'(ng), 32'h0000_0004);
        chk(32'(stall), 32'h0000_0000);
        for (int k = 0; k < 4; k++)
            chk(got[k], (wb[32*k +: 32] & ~lanes(m[4*k +: 4])) | (wa[32*k +: 32] & lanes(m[4*k +: 4])));
    endtask
    task automatic t_mode;
        ctl.issue(3'h0, 2'h2, 13'h0020, 1'b0, 1'b1);
        ctl.issue(3'h0, 2'h3, 13'h0000, 1'b0, 1'b1);
        ng = 0;
        repeat (40) @(negedge mclk_i);
        chk(32'(ng), 32'h0000_0000);
        read_words(3'h0, 2'h1, 13'h0000);
        chk(32'(ng), 32'h0000_0002);
        chk(got[0] | got[1], 32'h0000_0000);
        ctl.issue(3'h0, 2'h0, 13'h0031, 1'b0, 1'b1);
        read_words(3'h5, 2'h1, 13'h0000);
        chk(32'(ng), 32'h0000_0002);
        chk(got[0], 32'h8040_2010);
        ctl.issue(3'h0, 2'h0, 13'h0021, 1'b0, 1'b1);
        read_words(3'h5, 2'h1, 13'h0000);
        chk(32'(ng), 32'h0000_0002);
        chk(got[1], 32'h8002_2011);
    endtask
    task automatic t_power;
        ctl.issue(3'h7, 2'h0, 13'h0000, 1'b0, 1'b0);
        wait_ps(2'h2);
        ctl.issue(3'h7, 2'h0, 13'h0000, 1'b0, 1'b1);
        wait_ps(2'h0);
        ctl.issue(3'h2, 2'h0, 13'h0400, 1'b0, 1'b1);
        ctl.issue(3'h7, 2'h0, 13'h0000, 1'b0, 1'b0);
        wait_ps(2'h1);
        ctl.issue(3'h7, 2'h0, 13'h0000, 1'b0, 1'b1);
        wait_ps(2'h0);
        ctl.issue(3'h1, 2'h0, 13'h0000, 1'b0, 1'b0);
        wait_ps(2'h3);
        ctl.run_q = 1'b0;
        repeat (4) @(negedge mclk_i);
        ctl.cke_o = 1'b1;
        wait_ps(2'h0);
        ctl.run_q = 1'b1;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (30) @(negedge mclk_i);
        t_banks();
        t_write_read();
        t_mode();
        t_power();
        report_and_stop();
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // testbench
bind lpddr_pin_if lpddr_pin_if_asserts u_chk (.mclk_i, .rstn_i, .cke_i, .cs_n_i, .data_lines_o, .data_lines_oe_o,
    .byte_data_strobe_o, .byte_data_strobe_oe_o, .bank_open_o, .power_state_o);
